/* logic/qh_engine.sv */
// Queue-head engine of a USB 2.0 host controller: empty-schedule detection,
// queue head read/execute/write-back sequencing, error accumulation, halt
// and auto-advance, and micro-frame eligibility of periodic queue heads.
// Assumes fetch, transaction and write-back agents on pclk, and APB access.
// How it works
// [R1] Empty check right after each queue head fetch
// [R2] Start event sets the reclamation flag
// [R3] Async transaction sets the reclamation flag
// [R4] Head-of-list queue head clears reclamation flag
// [R5] Periodic work may clear reclamation; we don't
// [R6] Software sets head flag only on async heads
// [R7] Head flag with reclamation clear stops traversal
// [R8] Read, execute, write back, then next head
// [R9] Error bits accumulate, written back at completion
// [R10] Auto-advance to next descriptor at boundaries
// [R11] Halted queue: no transactions, no advance
// [R12] Software lays buffers out page by page
// [R13] Five pointers: 20K max, 16K any alignment
// [R14] Page index selects the starting buffer pointer
// [R15] Page crossing steps index while streaming
// [R16] Software provides enough pointers for byte count
// [R17] Address is page pointer joined with offset
// [R18] Offset and count adjusted, then written back
// [R19] Transaction inside one page keeps the index
// [R20] Ending on page end steps index before write-back
// [R21] Page index only ever increments by one
// [R22] Software gives periodic heads a non-zero mask
// [R23] Mask 0x01 selects micro-frame 0, 0x02 frame 1
// [R24] Periodic head eligible only in its masked micro-frames
//
// Design decisions made here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module qh_engine #(
    parameter int unsigned NUM_PAGES = qh_pkg::NUM_PAGES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,

    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [qh_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,

    // Schedule timing
    input wire logic periodic_done,
    input wire logic [qh_pkg::UFRAME_W-1:0] uframe,

    // Queue head fetch
    output logic qh_req,
    input wire logic qh_valid,
    input wire logic qh_hbit,
    input wire logic qh_periodic,
    input wire logic qh_reach,
    input wire logic [qh_pkg::SMASK_W-1:0] qh_smask,
    input wire logic qh_halted,
    input wire logic [qh_pkg::STAT_W-1:0] qh_status,
    input wire logic [NUM_PAGES*qh_pkg::PAGE_W-1:0] qh_pages,
    input wire logic [qh_pkg::OFFS_W-1:0] qh_offs,
    input wire logic [qh_pkg::CPAGE_W-1:0] qh_cpage,
    input wire logic [qh_pkg::BYTES_W-1:0] qh_bytes,

    // Bus transaction
    output logic xact_req,
    input wire logic byte_valid,
    input wire logic xact_done,
    input wire logic [qh_pkg::STAT_W-1:0] xact_err,
    input wire logic xact_halt,
    output logic [31:0] buf_addr,

    // Overlay write-back
    output logic wb_req,
    input wire logic wb_ack,
    output logic [qh_pkg::STAT_W-1:0] wb_status,
    output logic [qh_pkg::OFFS_W-1:0] wb_offs,
    output logic [qh_pkg::CPAGE_W-1:0] wb_cpage,
    output logic [qh_pkg::BYTES_W-1:0] wb_bytes,
    output logic wb_td_done,
    output logic wb_advance,
    output logic wb_halt
);
    typedef struct packed {
        qh_pkg::eng_state_t st;
        logic async_en;
        logic recl;
        logic hbit;
        logic periodic;
        logic elig;
        logic halted;
        logic [qh_pkg::STAT_W-1:0] status;
        logic td_done;
        logic advance;
        logic halt_hit;
        logic [31:0] prdata;
    } eng_t;

    eng_t eng_reg;
    eng_t eng_next;

    logic [31:0] rd_word;
    logic mapped;
    logic load;
    logic [qh_pkg::BYTES_W-1:0] walk_bytes;

    ////////////////////////////////////////////////////////////////////////
    // Register access: read data is captured in the setup cycle, so every
    // access takes exactly one access cycle
    assign mapped = (paddr == qh_pkg::CTRL_OFFS) || (paddr == qh_pkg::STATUS_OFFS);
    assign pready = psel && penable;
    assign pslverr = psel && penable && !mapped;

    assign prdata = eng_reg.prdata;

    always_comb
    begin
        rd_word = '0;
        if (paddr == qh_pkg::CTRL_OFFS)
            rd_word[qh_pkg::CTRL_ASYNC_EN_BIT] = eng_reg.async_en;
        else if (paddr == qh_pkg::STATUS_OFFS)
        begin
            rd_word[qh_pkg::STS_RECL_BIT] = eng_reg.recl;
            rd_word[qh_pkg::STS_ACTIVE_BIT] = (eng_reg.st != qh_pkg::ST_IDLE);
            rd_word[qh_pkg::STS_HALT_BIT] = eng_reg.halt_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    assign load = (eng_reg.st == qh_pkg::ST_FETCH) && qh_valid;

    qh_buf_walk #(
        .NUM_PAGES(NUM_PAGES)
    ) u_walk (
        .pclk(pclk),
        .presetn(presetn),
        .load(load),
        .pages(qh_pages),
        .offs_in(qh_offs),
        .cpage_in(qh_cpage),
        .bytes_in(qh_bytes),
        .byte_valid(byte_valid && (eng_reg.st == qh_pkg::ST_EXEC)),
        .addr(buf_addr),
        .offs(wb_offs),
        .cpage(wb_cpage),
        .bytes(walk_bytes)
    );

    assign wb_bytes = walk_bytes;

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        logic restart;
        logic wr_en;

        restart = 1'b0;
        wr_en = psel && penable && pwrite;
        eng_next = eng_reg;

        if (psel && !penable)
            eng_next.prdata = rd_word;
        if (wr_en && paddr == qh_pkg::CTRL_OFFS)
        begin
            eng_next.async_en = pwdata[qh_pkg::CTRL_ASYNC_EN_BIT];
            restart = pwdata[qh_pkg::CTRL_RESTART_BIT];
        end

        case (eng_reg.st)
            qh_pkg::ST_IDLE:
            begin
                // Leaving the periodic schedule or waking from sleep
                if (eng_next.async_en && (restart || periodic_done))
                begin
                    eng_next.recl = 1'b1; // [R2]
                    eng_next.st = qh_pkg::ST_FETCH;
                end
            end

            qh_pkg::ST_FETCH:
            begin
                if (qh_valid)
                begin
                    eng_next.hbit = qh_hbit;
                    eng_next.periodic = qh_periodic;
                    // A zero mask never matches, so a mis-built head is skipped and the next head fetched
                    eng_next.elig = qh_reach && qh_smask[uframe]; // [R23] [R24]
                    eng_next.halted = qh_halted;
                    eng_next.status = qh_status;
                    eng_next.st = qh_pkg::ST_CHECK; // [R1] [R8]
                end
            end

            qh_pkg::ST_CHECK:
            begin
                // Head flag is ignored on periodic heads, where it is undefined
                if (!eng_reg.async_en && !eng_reg.periodic)
                    eng_next.st = qh_pkg::ST_IDLE;
                else if (!eng_reg.periodic && eng_reg.hbit && !eng_reg.recl)
                    eng_next.st = qh_pkg::ST_IDLE; // [R1] [R7]
                else
                begin
                    if (!eng_reg.periodic && eng_reg.hbit)
                        eng_next.recl = 1'b0; // [R4]
                    if (eng_reg.halted)
                        eng_next.st = qh_pkg::ST_FETCH; // [R11]
                    else if (eng_reg.periodic && !eng_reg.elig)
                        eng_next.st = qh_pkg::ST_FETCH; // [R24]
                    else
                        eng_next.st = qh_pkg::ST_EXEC; // [R8]
                end
            end

            qh_pkg::ST_EXEC:
            begin
                if (xact_done)
                begin
                    eng_next.status = eng_reg.status | xact_err; // [R9]
                    // Periodic work leaves the flag alone; clearing is optional
                    if (!eng_reg.periodic)
                        eng_next.recl = 1'b1; // [R3] [R5]
                    eng_next.halt_hit = xact_halt; // [R11]
                    eng_next.td_done = (walk_bytes == '0) || xact_halt; // [R9]
                    eng_next.advance = (walk_bytes == '0) && !xact_halt; // [R10] [R11]
                    eng_next.st = qh_pkg::ST_WB; // [R8]
                end
            end

            qh_pkg::ST_WB:
            begin
                if (wb_ack)
                begin
                    eng_next.td_done = 1'b0;
                    eng_next.advance = 1'b0;
                    eng_next.st = qh_pkg::ST_FETCH; // [R8]
                end
            end

            default:
            begin
                eng_next.st = qh_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            eng_reg <= '0;
            eng_reg.st <= qh_pkg::ST_IDLE;
            eng_reg.async_en <= qh_pkg::ASYNC_EN_RST;
            eng_reg.recl <= qh_pkg::RECL_RST;
            eng_reg.prdata <= qh_pkg::PRDATA_RST;
        end
        else
            eng_reg <= eng_next;
    end

    ////////////////////////////////////////////////////////////////////////
    assign qh_req = (eng_reg.st == qh_pkg::ST_FETCH);
    assign xact_req = (eng_reg.st == qh_pkg::ST_EXEC);
    assign wb_req = (eng_reg.st == qh_pkg::ST_WB);

    assign wb_status = eng_reg.status;
    assign wb_td_done = eng_reg.td_done;
    assign wb_advance = eng_reg.advance;
    assign wb_halt = eng_reg.halt_hit;

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_CHECK_AFTER_FETCH: assert property ( // [R1]
        qh_req && qh_valid |=> eng_reg.st == qh_pkg::ST_CHECK)
        else $error("fetched head not checked next");

    AST_RECL_START: assert property ( // [R2]
        eng_reg.st == qh_pkg::ST_IDLE && eng_reg.async_en && periodic_done
        |=> eng_reg.recl && qh_req)
        else $error("start event did not set reclamation");

    AST_RECL_XACT: assert property ( // [R3]
        xact_req && xact_done && !eng_reg.periodic |=> eng_reg.recl ##0 wb_req)
        else $error("async transaction did not set reclamation");

    AST_RECL_CLEAR: assert property ( // [R4]
        eng_reg.st == qh_pkg::ST_CHECK && !eng_reg.periodic && eng_reg.hbit
        && eng_reg.recl && eng_reg.async_en |=> !eng_reg.recl)
        else $error("head flag did not clear reclamation");

    AST_EMPTY_STOP: assert property ( // [R7]
        eng_reg.st == qh_pkg::ST_CHECK && !eng_reg.periodic && eng_reg.hbit
        && !eng_reg.recl |=> eng_reg.st == qh_pkg::ST_IDLE ##1 !xact_req)
        else $error("empty schedule not stopped");

    AST_XACT_THEN_WB: assert property ( // [R8]
        xact_req && xact_done |=> wb_req && !xact_req && !qh_req)
        else $error("transaction not followed by write-back");

    AST_ERR_STICKY: assert property ( // [R9]
        xact_req && xact_done |=> (wb_status & $past(xact_err)) == $past(xact_err)
        && (wb_status & $past(wb_status)) == $past(wb_status))
        else $error("error bits not accumulated");

    AST_AUTO_ADVANCE: assert property ( // [R10]
        xact_req && xact_done && walk_bytes == '0 && !xact_halt
        |=> wb_req && wb_advance && wb_td_done)
        else $error("completed descriptor not advanced");

    AST_HALT_NO_XACT: assert property ( // [R11]
        eng_reg.st == qh_pkg::ST_CHECK && eng_reg.halted |=> !xact_req ##1 !xact_req)
        else $error("halted queue ran a transaction");

    AST_HALT_NO_ADV: assert property ( // [R11]
        wb_req && wb_halt |-> !wb_advance)
        else $error("halted queue advanced");

    AST_UFRAME_GATE: assert property ( // [R24]
        qh_req && qh_valid && qh_periodic && !qh_smask[uframe] |=> ##1 !xact_req)
        else $error("periodic head ran outside its micro-frame");

    AST_WB_NEXT_FETCH: assert property ( // [R8]
        wb_req && wb_ack
        |=> qh_req)
        else $error("no fetch after write-back");

    AST_PERIODIC_RECL: assert property ( // [R5]
        xact_req && eng_reg.periodic
        |=> $stable(eng_reg.recl))
        else $error("periodic work changed reclamation");

    AST_ADVANCE_DONE: assert property ( // [R10]
        wb_advance
        |-> wb_td_done)
        else $error("advance without completion");

    AST_WB_HOLD: assert property ( // [R18]
        wb_req && !wb_ack
        |=> $stable(wb_offs) && $stable(wb_bytes) && $stable(wb_cpage))
        else $error("write-back values moved");

    AST_ELIG_EXEC: assert property ( // [R24]
        eng_reg.st == qh_pkg::ST_CHECK && eng_reg.periodic && eng_reg.elig && !eng_reg.halted
        |=> xact_req)
        else $error("eligible periodic head not run");

endmodule
`default_nettype wire

/* inc/qh_pkg.sv */
// Constants and types shared by the queue-head engine and its buffer walker.
// Assumes a single 100 MHz clock domain; no timing counts are needed.
`default_nettype none
package qh_pkg;
    // Buffer pointer list geometry
    localparam int unsigned NUM_PAGES = 5;
    localparam int unsigned PAGE_W = 20;
    localparam int unsigned OFFS_W = 12;
    localparam int unsigned BYTES_W = 15;
    localparam int unsigned CPAGE_W = 3;
    localparam logic [11:0] OFFS_LAST = 12'hfff;
    // Queue head fields
    localparam int unsigned SMASK_W = 8;
    localparam int unsigned UFRAME_W = 3;
    localparam int unsigned STAT_W = 8;
    // Register map (byte addresses)
    localparam int unsigned ADDR_W = 8;
    localparam logic [7:0] CTRL_OFFS = 8'h00;
    localparam logic [7:0] STATUS_OFFS = 8'h04;
    // Control register fields
    localparam int unsigned CTRL_ASYNC_EN_BIT = 0;
    localparam int unsigned CTRL_RESTART_BIT = 1;
    // Status register fields
    localparam int unsigned STS_RECL_BIT = 0;
    localparam int unsigned STS_ACTIVE_BIT = 1;
    localparam int unsigned STS_HALT_BIT = 2;
    // Reset values
    localparam logic ASYNC_EN_RST = 1'b0;
    localparam logic RECL_RST = 1'b0;
    localparam logic [31:0] PRDATA_RST = 32'h0000_0000;
    // Engine sequencing
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FETCH,
        ST_CHECK,
        ST_EXEC,
        ST_WB
    } eng_state_t;
endpackage
`default_nettype wire

/* logic/qh_buf_walk.sv */
// Buffer walker: tracks current page index, offset and remaining bytes
// of the active transfer descriptor. Assumes load and byte strobes come
// from logic on pclk; one byte moves per byte_valid.
`timescale 1ns/1ps
`default_nettype none
module qh_buf_walk #(
    parameter int unsigned NUM_PAGES = qh_pkg::NUM_PAGES
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Overlay load
    input wire logic load,
    input wire logic [NUM_PAGES*qh_pkg::PAGE_W-1:0] pages,
    input wire logic [qh_pkg::OFFS_W-1:0] offs_in,
    input wire logic [qh_pkg::CPAGE_W-1:0] cpage_in,
    input wire logic [qh_pkg::BYTES_W-1:0] bytes_in,
    // Data stream
    input wire logic byte_valid,
    // Working values
    output logic [31:0] addr,
    output logic [qh_pkg::OFFS_W-1:0] offs,
    output logic [qh_pkg::CPAGE_W-1:0] cpage,
    output logic [qh_pkg::BYTES_W-1:0] bytes
);
    typedef struct packed {
        logic [qh_pkg::CPAGE_W-1:0] cpage;
        logic [qh_pkg::OFFS_W-1:0] offs;
        logic [qh_pkg::BYTES_W-1:0] bytes;
        logic [31:0] addr;
        logic [NUM_PAGES*qh_pkg::PAGE_W-1:0] pages;
    } walk_t;

    walk_t walk_reg;
    walk_t walk_next;
    logic [qh_pkg::PAGE_W-1:0] page_arr [NUM_PAGES];

    ////////////////////////////////////////////////////////////////////////
    genvar g;
    generate
        for (g = 0; g < NUM_PAGES; g++)
        begin : g_page
            assign page_arr[g] = load ? pages[g*qh_pkg::PAGE_W +: qh_pkg::PAGE_W]
                : walk_reg.pages[g*qh_pkg::PAGE_W +: qh_pkg::PAGE_W];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        walk_next = walk_reg;
        if (load)
        begin
            walk_next.cpage = cpage_in;
            walk_next.offs = offs_in;
            walk_next.bytes = bytes_in;
            walk_next.pages = pages;
        end
        else if (byte_valid)
        begin
            walk_next.offs = qh_pkg::OFFS_W'(walk_reg.offs + 1'b1); // [R18]
            // Crossing is caught on the byte that ends a page, so an exact fit
            // also steps the index before the status write-back
            if (walk_reg.offs == qh_pkg::OFFS_LAST)
                walk_next.cpage = qh_pkg::CPAGE_W'(walk_reg.cpage + 1'b1); // [R15] [R20] [R21]
            if (walk_reg.bytes != '0)
                walk_next.bytes = qh_pkg::BYTES_W'(walk_reg.bytes - 1'b1); // [R13] [R18]
        end
        // Each page has its own pointer, even for adjacent pages
        if (walk_next.cpage < qh_pkg::CPAGE_W'(NUM_PAGES))
            walk_next.addr = {page_arr[walk_next.cpage], walk_next.offs}; // [R14] [R17]
        else
            walk_next.addr = {{qh_pkg::PAGE_W{1'b0}}, walk_next.offs};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            walk_reg <= '0;
        else
            walk_reg <= walk_next;
    end

    assign addr = walk_reg.addr;
    assign offs = walk_reg.offs;
    assign cpage = walk_reg.cpage;
    assign bytes = walk_reg.bytes;

    ////////////////////////////////////////////////////////////////////////
    AST_CPAGE_STEP: assert property (@(posedge pclk) disable iff (!presetn) // [R21]
        !load |=> (cpage == $past(cpage)) || (cpage == qh_pkg::CPAGE_W'($past(cpage) + 1'b1)))
        else $error("page index moved by other than one");
    AST_PAGE_CROSS: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
        byte_valid && !load && offs == qh_pkg::OFFS_LAST
        |=> cpage == qh_pkg::CPAGE_W'($past(cpage) + 1'b1) && offs == '0)
        else $error("page crossing not followed");
    AST_SAME_PAGE: assert property (@(posedge pclk) disable iff (!presetn) // [R19]
        byte_valid && !load && offs != qh_pkg::OFFS_LAST |=> $stable(cpage))
        else $error("page index moved inside a page");
    AST_ADDR_FORM: assert property (@(posedge pclk) disable iff (!presetn) // [R17]
        cpage < qh_pkg::CPAGE_W'(NUM_PAGES)
        |-> addr == {walk_reg.pages[cpage*qh_pkg::PAGE_W +: qh_pkg::PAGE_W], offs})
        else $error("address not page pointer joined with offset");
    AST_BYTES_DOWN: assert property (@(posedge pclk) disable iff (!presetn) // [R18]
        byte_valid && !load && bytes != '0
        |=> bytes == qh_pkg::BYTES_W'($past(bytes) - 1'b1))
        else $error("remaining count not reduced");
endmodule
`default_nettype wire

/* verification/qh_far_model.sv */
// Far-side agents of the queue-head engine: head fetch, bus transaction
// and overlay write-back. Heads are queued by the bench; delays are random.
`timescale 1ns/1ps
`default_nettype none
module qh_far_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Buffer pages offered with every head
    input wire logic [qh_pkg::NUM_PAGES*qh_pkg::PAGE_W-1:0] pages,
    // Queue head fetch
    input wire logic qh_req,
    output logic qh_valid,
    output logic [62:0] head,
    output logic [qh_pkg::NUM_PAGES*qh_pkg::PAGE_W-1:0] qh_pages,
    // Bus transaction
    input wire logic xact_req,
    output logic byte_valid,
    output logic xact_done,
    output logic [7:0] xact_err,
    output logic xact_halt,
    // Write-back
    input wire logic wb_req,
    output logic wb_ack
);
    typedef struct packed {
        logic hb; logic per; logic rch; logic hlt; logic [7:0] sm; logic [7:0] st;
        logic [11:0] of; logic [2:0] cp; logic [14:0] by; logic [3:0] n;
        logic [7:0] er; logic xh;
    } rec_t;
    rec_t q[$];
    rec_t cur = '0;
    int k;
    logic bv;
    initial
    begin
        qh_valid = 1'b0; head = '0; qh_pages = '0; byte_valid = 1'b0;
        xact_done = 1'b0; xact_err = 8'h00; xact_halt = 1'b0; wb_ack = 1'b0;
    end
    task automatic push_head(input rec_t r);
        q.push_back(r);
    endtask
    ////////////////////////////////////////////////////////////
    // Fields outside the valid cycle toggle so stale values are never trusted
    always
    begin
        @(posedge pclk);
        if (presetn && qh_req && q.size() > 0)
        begin
            repeat ($urandom_range(2)) @(posedge pclk);
            cur = q.pop_front();
            head <= cur;
            qh_pages <= pages;
            qh_valid <= 1'b1;
            @(posedge pclk);
            qh_valid <= 1'b0;
        end
        head <= ~head;
        qh_pages <= ~qh_pages;
    end
    // Done always comes a cycle after the last byte
    always
    begin
        @(posedge pclk);
        if (presetn && xact_req)
        begin
            k = 0;
            while (k < cur.n)
            begin
                bv = 1'($urandom_range(1));
                byte_valid <= bv;
                k += bv;
                @(posedge pclk);
            end
            byte_valid <= 1'b0; xact_done <= 1'b1; xact_err <= cur.er; xact_halt <= cur.xh;
            @(posedge pclk);
            xact_done <= 1'b0; xact_err <= ~cur.er; xact_halt <= ~cur.xh;
        end
    end
    always
    begin
        @(posedge pclk);
        if (presetn && wb_req)
        begin
            repeat ($urandom_range(2)) @(posedge pclk);
            wb_ack <= 1'b1;
            @(posedge pclk);
            wb_ack <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* verification/usb_host_queue_head_engine_test.sv */
// Self-checking bench of the queue-head engine: APB master, far-side model,
// expectation queues checked by a monitor. Single 100 MHz clock.
`timescale 1ns/1ps
`default_nettype none
module usb_host_queue_head_engine_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, periodic_done = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, buf_addr;
    logic [2:0] uframe = 3'h0;
    logic pready, pslverr, qh_req, qh_valid, xact_req, byte_valid, xact_done, xact_halt;
    logic wb_req, wb_ack, wb_td_done, wb_advance, wb_halt;
    logic [62:0] head;
    logic [7:0] xact_err, wb_status;
    logic [99:0] qh_pages, pages;
    logic [11:0] wb_offs;
    logic [2:0] wb_cpage;
    logic [14:0] wb_bytes;
    int fails = 0;
    int compares = 0;
    logic [31:0] exp_addr[$];
    logic [40:0] exp_wb[$];
    logic [33:0] exp_ap[$];
    logic [33:0] e;
    logic xact_seen = 1'b0;
    qh_engine #(.NUM_PAGES(qh_pkg::NUM_PAGES)) qh_engine_inst (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .periodic_done, .uframe, .qh_req, .qh_valid, .qh_hbit(head[62]),
        .qh_periodic(head[61]), .qh_reach(head[60]), .qh_halted(head[59]),
        .qh_smask(head[58:51]), .qh_status(head[50:43]), .qh_pages, .qh_offs(head[42:31]),
        .qh_cpage(head[30:28]), .qh_bytes(head[27:13]), .xact_req, .byte_valid, .xact_done,
        .xact_err, .xact_halt, .buf_addr, .wb_req, .wb_ack, .wb_status, .wb_offs, .wb_cpage,
        .wb_bytes, .wb_td_done, .wb_advance, .wb_halt);
    qh_far_model qh_far_model_inst (.pclk, .presetn, .pages, .qh_req, .qh_valid, .head,
        .qh_pages, .xact_req, .byte_valid, .xact_done, .xact_err, .xact_halt, .wb_req, .wb_ack);
    initial forever #5 pclk = ~pclk;
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        compares++;
        if (got !== exp)
        begin
            fails++;
            $display("ERROR %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic summarize();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // Reads carry expected data in d; write data is only for writes
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic err);
        int k;
        k = 0;
        exp_ap.push_back({w, err, w ? 32'h0 : d});
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= w ? d : $urandom;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && k < 50)
        begin
            k++;
            @(posedge pclk);
        end
        if (k >= 50) fails++;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic hd(input logic hb, per, rch, hlt, input logic [7:0] sm, st,
            input logic [11:0] of, input logic [2:0] cp, input logic [14:0] by,
            input logic [3:0] n, input logic [7:0] er, input logic xh, run);
        logic [12:0] s;
        logic [14:0] nb;
        qh_far_model_inst.push_head({hb, per, rch, hlt, sm, st, of, cp, by, n, er, xh});
        s = 13'(of) + 13'(n);
        nb = (by > 15'(n)) ? by - 15'(n) : 15'h0;
        if (run)
        begin
            exp_addr.push_back({pages[int'(cp)*20 +: 20], of});
            exp_wb.push_back({st | er, s[11:0], cp + 3'(s[12]), nb, nb == 0 || xh, nb == 0 && !xh, xh});
        end
    endtask
    // Idle is only trusted once the model has nothing left to hand out
    task automatic wait_idle();
        int k;
        k = 0;
        while ((qh_far_model_inst.q.size() > 0 || qh_req || xact_req || wb_req) && k < 3000)
        begin
            k++;
            @(posedge pclk);
        end
        if (k >= 3000) fails++;
        repeat (4) @(posedge pclk);
        chk(64'(qh_req), 64'h0, "fetch after stop");
    endtask
    always @(posedge pclk)
    begin
        if (presetn)
        begin
            if (xact_req && !xact_seen)
                chk(64'(buf_addr), 64'(exp_addr.size() ? exp_addr.pop_front() : 'x), "addr");
            xact_seen = xact_req;
            if (wb_req && wb_ack)
                chk({wb_status, wb_offs, wb_cpage, wb_bytes, wb_td_done, wb_advance, wb_halt}, 64'(exp_wb.size() ? exp_wb.pop_front() : 'x), "wb");
            if (psel && penable && pready)
            begin
                e = exp_ap.size() ? exp_ap.pop_front() : 'x;
                chk({pwrite, pslverr, pwrite ? 32'h0 : prdata}, 64'(e), "apb");
            end
        end
    end
    ////////////////////////////////////////////////////////////
    initial
    begin
        for (int i = 0; i < 5; i++) pages[i*20 +: 20] = 20'h9a000 + 20'(i * 7);
        void'($urandom(32'hbfd0da8c));
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, qh_pkg::CTRL_OFFS, 32'h0, 0);
        apb(0, qh_pkg::STATUS_OFFS, 32'h0, 0);
        apb(1, 8'h08, $urandom, 1);
        apb(0, 8'h08, 32'h0, 1);
        apb(1, qh_pkg::STATUS_OFFS, 32'hffff_ffff, 0);
        apb(0, qh_pkg::STATUS_OFFS, 32'h0, 0);
        hd(1, 0, 1, 0, 8'h00, 8'h01, 12'hffe, 3'd0, 15'd5, 4'd2, 8'h04, 0, 1);
        hd(1, 0, 1, 0, 8'h00, 8'h00, 12'($urandom_range(12'hff0)), 3'd1, 15'd2, 4'd2, 8'h00, 0, 1);
        hd(0, 0, 1, 0, 8'h00, 8'h20, 12'hffe, 3'd2, 15'd20480, 4'd3, 8'h02, 0, 1);
        hd(1, 0, 1, 1, 8'h00, 8'h00, 12'h0, 3'd0, 15'd9, 4'd1, 8'h00, 0, 0);
        hd(1, 0, 1, 0, 8'h00, 8'h00, 12'h0, 3'd0, 15'd9, 4'd1, 8'h00, 0, 0);
        apb(1, qh_pkg::CTRL_OFFS, 32'h3, 0);
        wait_idle();
        apb(0, qh_pkg::STATUS_OFFS, 32'h0, 0);
        apb(0, qh_pkg::CTRL_OFFS, 32'h1, 0);
        for (int u = 0; u < 2; u++)
        begin
            uframe <= 3'(u);
            hd(0, 1, 1, 0, 8'(1 << (1 - u)), 8'h00, 12'h0, 3'd0, 15'd4, 4'd1, 8'h00, 0, 0);
            hd(0, 1, 0, 0, 8'(1 << u), 8'h00, 12'h0, 3'd0, 15'd4, 4'd1, 8'h00, 0, 0);
            hd(0, 1, 1, 0, 8'(1 << u), 8'h40, 12'h800, 3'(u + 3), 15'd8, 4'd4, 8'h08, u == 0, 1);
            hd(1, 0, 1, 1, 8'h00, 8'h00, 12'h0, 3'd0, 15'd9, 4'd1, 8'h00, 0, 0);
            hd(1, 0, 1, 0, 8'h00, 8'h00, 12'h0, 3'd0, 15'd9, 4'd1, 8'h00, 0, 0);
            periodic_done <= 1'b1;
            @(posedge pclk);
            periodic_done <= 1'b0;
            wait_idle();
            apb(0, qh_pkg::STATUS_OFFS, (u == 0) ? 32'h1 << qh_pkg::STS_HALT_BIT : 32'h0, 0);
        end
        chk(64'(exp_wb.size() + exp_addr.size()), 64'h0, "missing transactions");
        summarize();
    end
    initial
    begin
        #100000;
        fails++;
        $display("ERROR %0t watchdog expired", $time);
        summarize();
    end
endmodule
`default_nettype wire
